// *** inc/ddc_cfg_pkg.sv ***
// register map, field layout and filter stage mask bits for the downconverter configuration block
// assumes a 12-bit byte-address register port and one sample clock
package ddc_cfg_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 14;
   localparam int NCO_W = 48;
   localparam int NCO_BYTES = 6;
   localparam int FACTOR_W = 6;
   localparam logic [ADDR_W-1:0] PHASE_STEP_BASE = 12'h316;
   localparam logic [ADDR_W-1:0] PHASE_OFFSET_BASE = 12'h31D;
   localparam logic [ADDR_W-1:0] FIRST_PATH_PHASE_OFFSET_BYTE5 = 12'h322;
   localparam logic [ADDR_W-1:0] FIRST_PATH_TEST_ENABLE = 12'h327;
   localparam logic [ADDR_W-1:0] SECOND_PATH_CONFIGURATION = 12'h330;
   localparam logic [ADDR_W-1:0] SECOND_PATH_EXTENDED_DECIMATION = 12'h331;
   localparam logic [ADDR_W-1:0] TEST_PATTERN_CONFIG = 12'h550;
   localparam logic [ADDR_W-1:0] SECOND_PATH_STATUS = 12'h5F0;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   // field positions
   localparam int TEST_EN_BIT = 0;
   localparam int CFG_RSVD_BIT = 7;
   localparam int GAIN_BIT = 6;
   localparam int IF_MODE_HI = 5;
   localparam int IF_MODE_LO = 4;
   localparam int C2R_BIT = 3;
   localparam int DEC_SEL_HI = 2;
   localparam int EXT_HI = 7;
   localparam int EXT_LO = 4;
   localparam int PAT_HI = 3;
   localparam int STATUS_BAD_BIT = 7;
   // filter stage mask bits
   localparam int HALFBAND_STAGE_ONE = 0;
   localparam int HALFBAND_STAGE_TWO = 1;
   localparam int HALFBAND_STAGE_THREE = 2;
   localparam int HALFBAND_STAGE_FOUR = 3;
   localparam int THIRDBAND_STAGE_ONE = 4;
   localparam int THIRDBAND_STAGE_TWO = 5;
   localparam int FIFTHBAND_STAGE_TWO = 6;
   localparam int STAGES = 7;
   localparam logic [2:0] DEC_EXTENDED = 3'h7;
   localparam logic [STAGES-1:0] MASK_RESET = 7'h03;
   localparam logic [FACTOR_W-1:0] FACTOR_RESET = 6'h04;
   typedef enum logic [1:0] {
      IF_VARIABLE = 2'h0,
      IF_ZERO = 2'h1,
      IF_QUARTER = 2'h2,
      IF_TEST = 2'h3
   } if_mode_e;
   // test pattern codes
   localparam logic [3:0] PAT_MIDSCALE = 4'h1;
   localparam logic [3:0] PAT_POS_FULL = 4'h2;
   localparam logic [3:0] PAT_NEG_FULL = 4'h3;
   localparam logic [3:0] PAT_CHECKER = 4'h4;
   localparam logic [3:0] PAT_RAMP = 4'h5;
   localparam logic [SAMPLE_W-1:0] CHECKER_WORD = 14'h2AAA;
   localparam logic [SAMPLE_W-1:0] POS_FULL = 14'h1FFF;
   localparam logic [SAMPLE_W-1:0] NEG_FULL = 14'h2000;
endpackage : ddc_cfg_pkg

// *** design/ddc_decimation_config.sv ***
// downconverter configuration registers, first path offset/test and second path decimation
// assumes samples arrive on core_clk from the converter core; outputs feed the link framer
// Summary of operation
// - phase offset bits 47:40, RW, reset zero
// - test enable bit0 replaces first I output
// - four-bit select picks the test pattern
// - gain bit doubles second path output outside IF test mode
// - complex-to-real: I only, fs/4 mix, halved
// - code 000: two halfbands, by 4/2
// - code 001: three halfbands, by 8/4
// - code 010: four halfbands, by 16/8
// - code 011: first halfband, by 2/1
// - code 100: halfband plus thirdband, 6/3
// - code 101: two halfbands plus thirdband, 12/6
// - code 110: three halfbands plus thirdband, 24/12
// - code 111 uses extended field bits 7:4
// - extended 0: thirdband plus four halfbands, 48/24
// - extended 10: fifthband plus halfband, 10/5
// - extended 11: fifthband plus two halfbands, 20/10
// - extended 100: fifthband plus three halfbands, 40/20
// - extended 111: first thirdband, by 3 only
// - extended 1000: fifthband plus thirdband, by 15
// - extended 1001: halfband, fifthband, thirdband, by 30
// - 48-bit two's complement NCO phase step
`timescale 1ns/1ps
module ddc_decimation_config
   import ddc_cfg_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   // samples from the converter core
   input wire logic [SAMPLE_W-1:0] sampleI,
   input wire logic [SAMPLE_W-1:0] sampleQ,
   input wire logic sampleValid,
   // first path toward the framer
   output logic [SAMPLE_W-1:0] firstI,
   output logic firstValid,
   output logic [NCO_W-1:0] ncoPhase,
   // second path toward the framer
   output logic [SAMPLE_W-1:0] secondI,
   output logic [SAMPLE_W-1:0] secondQ,
   output logic secondIValid,
   output logic secondQValid,
   output logic [STAGES-1:0] stageMask,
   output logic [FACTOR_W-1:0] decimFactor,
   output logic [1:0] ifMode,
   output logic configBad
);
   logic rstMeta_r;
   logic rstSync_r;
   logic rstLocal_n;
   logic [DATA_W-1:0] stepByte_r [NCO_BYTES];
   logic [DATA_W-1:0] offsetByte_r [NCO_BYTES];
   logic testEnable_r;
   logic [DATA_W-1:0] secondCfg_r;
   logic [EXT_HI-EXT_LO:0] extDec_r;
   logic [PAT_HI:0] patSel_r;
   logic [NCO_W-1:0] phaseStep;
   logic [NCO_W-1:0] phaseOffset;
   logic [NCO_W-1:0] phaseAcc_r;
   logic [SAMPLE_W-1:0] ramp_r;
   logic [SAMPLE_W-1:0] pattern;
   logic c2r;
   logic [FACTOR_W-1:0] complexFactor;
   logic [FACTOR_W-1:0] factor;
   logic bad;
   logic [FACTOR_W-1:0] decCount_r;
   logic [1:0] mixPhase_r;
   logic [SAMPLE_W-1:0] gainI;
   logic [SAMPLE_W-1:0] gainQ;
   logic [SAMPLE_W-1:0] realOut;
   logic [STAGES-1:0] stageMask_nxt;

   // one mask bit per filter stage; a chain is the OR of its stages
   localparam logic [STAGES-1:0] HALF1_M = STAGES'(1) << HALFBAND_STAGE_ONE;
   localparam logic [STAGES-1:0] HALF2_M = STAGES'(1) << HALFBAND_STAGE_TWO;
   localparam logic [STAGES-1:0] HALF3_M = STAGES'(1) << HALFBAND_STAGE_THREE;
   localparam logic [STAGES-1:0] HALF4_M = STAGES'(1) << HALFBAND_STAGE_FOUR;
   localparam logic [STAGES-1:0] THIRD1_M = STAGES'(1) << THIRDBAND_STAGE_ONE;
   localparam logic [STAGES-1:0] THIRD2_M = STAGES'(1) << THIRDBAND_STAGE_TWO;
   localparam logic [STAGES-1:0] FIFTH2_M = STAGES'(1) << FIFTHBAND_STAGE_TWO;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end
   assign rstLocal_n = rstSync_r;

   // register writes
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         for (int b = 0; b < NCO_BYTES; b++) begin
            stepByte_r[b] <= REG_RESET;
            offsetByte_r[b] <= REG_RESET;
         end
         testEnable_r <= 1'b0;
         secondCfg_r <= REG_RESET;
         extDec_r <= '0;
         patSel_r <= '0;
      end else if (regWr) begin
         for (int b = 0; b < NCO_BYTES; b++) begin
            if (regAddr == PHASE_STEP_BASE + ADDR_W'(b)) begin
               stepByte_r[b] <= regWrData;
            end
            if (regAddr == PHASE_OFFSET_BASE + ADDR_W'(b)) begin
               offsetByte_r[b] <= regWrData;
            end
         end
         if (regAddr == FIRST_PATH_TEST_ENABLE) begin
            testEnable_r <= regWrData[TEST_EN_BIT];
         end
         if (regAddr == SECOND_PATH_CONFIGURATION) begin
            secondCfg_r <= regWrData;
         end
         if (regAddr == SECOND_PATH_EXTENDED_DECIMATION) begin
            extDec_r <= regWrData[EXT_HI:EXT_LO];
         end
         if (regAddr == TEST_PATTERN_CONFIG) begin
            patSel_r <= regWrData[PAT_HI:0];
         end
      end
   end

   // register reads, data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         regRdData <= REG_RESET;
      end else begin
         regRdData <= REG_RESET;
         if (regRd) begin
            for (int b = 0; b < NCO_BYTES; b++) begin
               if (regAddr == PHASE_STEP_BASE + ADDR_W'(b)) begin
                  regRdData <= stepByte_r[b];
               end
               if (regAddr == PHASE_OFFSET_BASE + ADDR_W'(b)) begin
                  regRdData <= offsetByte_r[b];
               end
            end
            unique case (regAddr)
               FIRST_PATH_TEST_ENABLE: regRdData <= {7'h00, testEnable_r};
               SECOND_PATH_CONFIGURATION: regRdData <= secondCfg_r;
               SECOND_PATH_EXTENDED_DECIMATION: regRdData <= {extDec_r, 4'h0};
               TEST_PATTERN_CONFIG: regRdData <= {4'h0, patSel_r};
               SECOND_PATH_STATUS: regRdData <= {bad, 1'b0, factor};
               default: ;
            endcase
         end
      end
   end

   // NCO: 48-bit two's complement step, offset added after the accumulator
   always_comb begin
      for (int b = 0; b < NCO_BYTES; b++) begin
         phaseStep[b*DATA_W +: DATA_W] = stepByte_r[b];
         phaseOffset[b*DATA_W +: DATA_W] = offsetByte_r[b];
      end
   end

   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         phaseAcc_r <= '0;
         ncoPhase <= '0;
      end else begin
         if (sampleValid) begin
            phaseAcc_r <= phaseAcc_r + phaseStep;
         end
         ncoPhase <= phaseAcc_r + phaseOffset;
      end
   end

   // pattern generator shared by both paths
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         ramp_r <= '0;
      end else if (sampleValid) begin
         ramp_r <= ramp_r + SAMPLE_W'(1);
      end
   end

   always_comb begin
      unique case (patSel_r)
         PAT_MIDSCALE: pattern = '0;
         PAT_POS_FULL: pattern = POS_FULL;
         PAT_NEG_FULL: pattern = NEG_FULL;
         PAT_CHECKER: pattern = ramp_r[0] ? ~CHECKER_WORD : CHECKER_WORD;
         PAT_RAMP: pattern = ramp_r;
         default: pattern = '0;
      endcase
   end

   // first path I output
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         firstI <= '0;
         firstValid <= 1'b0;
      end else begin
         firstValid <= sampleValid;
         if (sampleValid) begin
            firstI <= testEnable_r ? pattern : sampleI;
         end
      end
   end

   // second path chain and rate decode
   assign c2r = secondCfg_r[C2R_BIT];
   assign ifMode = secondCfg_r[IF_MODE_HI:IF_MODE_LO];

   always_comb begin
      stageMask_nxt = '0;
      complexFactor = FACTOR_W'(4);
      bad = 1'b0;
      unique case (secondCfg_r[DEC_SEL_HI:0])
         3'h0: begin
            stageMask_nxt = HALF1_M | HALF2_M;
            complexFactor = FACTOR_W'(4);
         end
         3'h1: begin
            stageMask_nxt = HALF1_M | HALF2_M | HALF3_M;
            complexFactor = FACTOR_W'(8);
         end
         3'h2: begin
            stageMask_nxt = HALF1_M | HALF2_M | HALF3_M | HALF4_M;
            complexFactor = FACTOR_W'(16);
         end
         3'h3: begin
            stageMask_nxt = HALF1_M;
            complexFactor = FACTOR_W'(2);
         end
         3'h4: begin
            stageMask_nxt = HALF1_M | THIRD2_M;
            complexFactor = FACTOR_W'(6);
         end
         3'h5: begin
            stageMask_nxt = HALF1_M | HALF2_M | THIRD2_M;
            complexFactor = FACTOR_W'(12);
         end
         3'h6: begin
            stageMask_nxt = HALF1_M | HALF2_M | HALF3_M | THIRD2_M;
            complexFactor = FACTOR_W'(24);
         end
         DEC_EXTENDED: begin
            unique case (extDec_r)
               4'h0: begin
                  stageMask_nxt = HALF1_M | HALF2_M | HALF3_M | HALF4_M | THIRD2_M;
                  complexFactor = FACTOR_W'(48);
               end
               4'h2: begin
                  stageMask_nxt = HALF1_M | FIFTH2_M;
                  complexFactor = FACTOR_W'(10);
               end
               4'h3: begin
                  stageMask_nxt = HALF1_M | HALF2_M | FIFTH2_M;
                  complexFactor = FACTOR_W'(20);
               end
               4'h4: begin
                  stageMask_nxt = HALF1_M | HALF2_M | HALF3_M | FIFTH2_M;
                  complexFactor = FACTOR_W'(40);
               end
               4'h7: begin
                  stageMask_nxt = THIRD1_M;
                  complexFactor = FACTOR_W'(3);
                  bad = c2r;
               end
               4'h8: begin
                  stageMask_nxt = THIRD1_M | FIFTH2_M;
                  complexFactor = FACTOR_W'(15);
                  bad = c2r;
               end
               4'h9: begin
                  stageMask_nxt = HALF2_M | THIRD1_M | FIFTH2_M;
                  complexFactor = FACTOR_W'(30);
                  bad = c2r;
               end
               default: begin
                  stageMask_nxt = '0;
                  bad = 1'b1;
               end
            endcase
         end
      endcase
   end

   // halved rate only where the half is whole; odd factors are flagged above
   assign factor = (c2r && !bad) ? (complexFactor >> 1) : complexFactor;

   // status outputs lag the live decode by one edge; the datapath uses the live decode
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         stageMask <= MASK_RESET;
         decimFactor <= FACTOR_RESET;
         configBad <= 1'b0;
      end else begin
         stageMask <= stageMask_nxt;
         decimFactor <= factor;
         configBad <= bad;
      end
   end

   // gain stage: doubling saturates instead of wrapping
   function automatic logic [SAMPLE_W-1:0] applyGain(input logic [SAMPLE_W-1:0] s,
                                                      input logic dbl);
      logic [SAMPLE_W:0] wide;
      wide = {s[SAMPLE_W-1], s} <<< 1;
      if (!dbl) begin
         applyGain = s;
      end else if (wide[SAMPLE_W] != wide[SAMPLE_W-1]) begin
         applyGain = s[SAMPLE_W-1] ? NEG_FULL : POS_FULL;
      end else begin
         applyGain = wide[SAMPLE_W-1:0];
      end
   endfunction : applyGain

   assign gainI = (ifMode == IF_TEST) ? pattern : applyGain(sampleI, secondCfg_r[GAIN_BIT]);
   assign gainQ = (ifMode == IF_TEST) ? pattern : applyGain(sampleQ, secondCfg_r[GAIN_BIT]);

   // negating full-scale negative would wrap back onto itself, so clip it
   function automatic logic [SAMPLE_W-1:0] negSat(input logic [SAMPLE_W-1:0] s);
      if (s == NEG_FULL) begin
         negSat = POS_FULL;
      end else begin
         negSat = -s;
      end
   endfunction : negSat

   // extra fs/4 mix for real output: I, -Q, -I, Q
   always_comb begin
      unique case (mixPhase_r)
         2'h0: realOut = gainI;
         2'h1: realOut = negSat(gainQ);
         2'h2: realOut = negSat(gainI);
         2'h3: realOut = gainQ;
      endcase
   end

   // decimation counter; a bad setting produces no output samples
   always_ff @(posedge core_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         decCount_r <= '0;
         mixPhase_r <= '0;
         secondI <= '0;
         secondQ <= '0;
         secondIValid <= 1'b0;
         secondQValid <= 1'b0;
      end else begin
         secondIValid <= 1'b0;
         secondQValid <= 1'b0;
         if (sampleValid && !bad) begin
            if (decCount_r >= factor - FACTOR_W'(1)) begin
               decCount_r <= '0;
               mixPhase_r <= mixPhase_r + 2'h1;
               secondI <= c2r ? realOut : gainI;
               secondQ <= c2r ? '0 : gainQ;
               secondIValid <= 1'b1;
               secondQValid <= !c2r;
            end else begin
               decCount_r <= decCount_r + FACTOR_W'(1);
            end
         end
      end
   end
endmodule : ddc_decimation_config

// *** bench/ddc_core_model.sv ***
// converter core stand-in: ramps I, offsets Q, one sample per cycle while run is high
// assumes the bench drives run on rising edges of core_clk
`timescale 1ns/1ps
module ddc_core_model
   import ddc_cfg_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // bench control
   input wire logic run,
   // samples toward the block
   output logic [SAMPLE_W-1:0] sampleI,
   output logic [SAMPLE_W-1:0] sampleQ,
   output logic sampleValid
);
   logic [SAMPLE_W-1:0] cnt_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 14'h0000;
         sampleValid <= 1'b0;
      end else begin
         sampleValid <= run;
         cnt_r <= run ? cnt_r + 14'h0003 : cnt_r;
      end
   end
   // idle data is inverted so a stale capture never matches
   assign sampleI = sampleValid ? cnt_r : ~cnt_r;
   assign sampleQ = sampleValid ? cnt_r + 14'h0100 : ~cnt_r;
endmodule : ddc_core_model

// *** bench/ddc_decimation_config_sva.sv ***
// port checker for the downconverter configuration block
// assumes one clock; bound to the design module by the bind below
`timescale 1ns/1ps
module ddc_decimation_config_sva
   import ddc_cfg_pkg::*;
(
   // clock, reset, register port
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [DATA_W-1:0] regRdData,
   // second path
   input wire logic secondIValid,
   input wire logic secondQValid,
   input wire logic [STAGES-1:0] stageMask,
   input wire logic [FACTOR_W-1:0] decimFactor,
   input wire logic [1:0] ifMode,
   input wire logic configBad
);
   logic [1:0] wrIf_r;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge core_clk) wrIf_r <= regWrData[5:4];
   a_offset_readback: assert property ((regWr && regAddr == FIRST_PATH_PHASE_OFFSET_BYTE5) ##3
      (regRd && regAddr == FIRST_PATH_PHASE_OFFSET_BYTE5) |=> regRdData == $past(regWrData, 4))
      else $error("offset byte not read back");
   a_test_bit_only: assert property (regRd && regAddr == FIRST_PATH_TEST_ENABLE
      |=> regRdData[7:1] == 7'h00) else $error("test enable reserved bits set");
   a_ext_low_zero: assert property (regRd && regAddr == SECOND_PATH_EXTENDED_DECIMATION
      |=> regRdData[3:0] == 4'h0) else $error("extended field low bits set");
   a_ifmode_follow: assert property (regWr && regAddr == SECOND_PATH_CONFIGURATION
      |=> ifMode == wrIf_r) else $error("IF mode not from written field");
   a_half_only: assert property (stageMask == 7'h01 |-> decimFactor inside {6'h02, 6'h01})
      else $error("single halfband factor wrong");
   a_three_half: assert property (stageMask == 7'h07 |-> decimFactor inside {6'h08, 6'h04})
      else $error("three halfband factor wrong");
   a_half_third: assert property (stageMask == 7'h21 |-> decimFactor inside {6'h06, 6'h03})
      else $error("halfband thirdband factor wrong");
   a_bad_silent: assert property (configBad |-> !secondIValid)
      else $error("output under refused config");
   a_q_with_i: assert property (secondQValid |-> secondIValid)
      else $error("Q output without I");
   c_out: cover property (secondIValid);
   c_bad: cover property (configBad);
   c_fifth: cover property (stageMask == 7'h50);
endmodule : ddc_decimation_config_sva
bind ddc_decimation_config ddc_decimation_config_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .secondIValid(secondIValid), .secondQValid(secondQValid),
   .stageMask(stageMask), .decimFactor(decimFactor), .ifMode(ifMode), .configBad(configBad));

// *** bench/ddc_decimation_config_tb.sv ***
// self-checking bench: registers, decimation table, sample streaming
// assumes the core model and the bound checker
`timescale 1ns/1ps
module ddc_decimation_config_tb;
   import ddc_cfg_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = 12'h000;
   logic [DATA_W-1:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic run = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic [SAMPLE_W-1:0] sampleI, sampleQ, firstI, secondI, secondQ, lastI, lastQ;
   logic sampleValid, firstValid, secondIValid, secondQValid, configBad;
   logic [NCO_W-1:0] ncoPhase;
   logic [STAGES-1:0] stageMask;
   logic [FACTOR_W-1:0] decimFactor;
   logic [1:0] ifMode;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   always #25 core_clk = ~core_clk;
   ddc_core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .run(run), .sampleI(sampleI),
      .sampleQ(sampleQ), .sampleValid(sampleValid));
   ddc_decimation_config u_dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .sampleI(sampleI), .sampleQ(sampleQ), .sampleValid(sampleValid), .firstI(firstI),
      .firstValid(firstValid), .ncoPhase(ncoPhase), .secondI(secondI), .secondQ(secondQ),
      .secondIValid(secondIValid), .secondQValid(secondQValid), .stageMask(stageMask),
      .decimFactor(decimFactor), .ifMode(ifMode), .configBad(configBad));
   always @(posedge core_clk) if (sampleValid) begin
      lastI <= sampleI;
      lastQ <= sampleQ;
   end
   task automatic report_and_stop();
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      // status outputs settle one edge after the write lands
      @(posedge core_clk);
      #1;
   endtask : wr
   task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 check("regRdData", 16'(exp), 16'(regRdData));
   endtask : rc
   task automatic t_regs();
      rc(FIRST_PATH_PHASE_OFFSET_BYTE5, 8'h00);
      rc(FIRST_PATH_TEST_ENABLE, 8'h00);
      rc(SECOND_PATH_CONFIGURATION, 8'h00);
      rc(SECOND_PATH_EXTENDED_DECIMATION, 8'h00);
      check("decimFactor", 16'h0004, 16'(decimFactor));
      wr(FIRST_PATH_PHASE_OFFSET_BYTE5, 8'hA5);
      rc(FIRST_PATH_PHASE_OFFSET_BYTE5, 8'hA5);
      check("ncoPhase", 16'h00A5, 16'(ncoPhase[47:40]));
      wr(FIRST_PATH_TEST_ENABLE, 8'hFE);
      rc(FIRST_PATH_TEST_ENABLE, 8'h00);
      wr(SECOND_PATH_EXTENDED_DECIMATION, 8'hFF);
      rc(SECOND_PATH_EXTENDED_DECIMATION, 8'hF0);
      rc(12'h123, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(SECOND_PATH_CONFIGURATION, 8'(m << 4));
         check("ifMode", 16'(m), 16'(ifMode));
      end
   endtask : t_regs
   task automatic t_decim();
      logic [5:0] cx [14] = '{4, 8, 16, 2, 6, 12, 24, 48, 10, 20, 40, 3, 15, 30};
      logic [5:0] rl [14] = '{2, 4, 8, 1, 3, 6, 12, 24, 5, 10, 20, 0, 0, 0};
      logic [6:0] mk [14] = '{7'h03, 7'h07, 7'h0F, 7'h01, 7'h21, 7'h23, 7'h27, 7'h2F, 7'h41,
         7'h43, 7'h47, 7'h10, 7'h50, 7'h52};
      logic [3:0] ex [7] = '{0, 2, 3, 4, 7, 8, 9};
      logic bad;
      // extended field holds 2 in the first pass and 9 in the second while codes below 7 are set, so it must be ignored
      wr(SECOND_PATH_EXTENDED_DECIMATION, 8'h20);
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 14; k++) begin
            bad = (c == 1 && k > 10);
            if (k > 6) wr(SECOND_PATH_EXTENDED_DECIMATION, {ex[k-7], 4'h0});
            wr(SECOND_PATH_CONFIGURATION, {4'h0, c[0], (k > 6) ? 3'h7 : k[2:0]});
            if (!bad) check("decimFactor", 16'(c ? rl[k] : cx[k]), 16'(decimFactor));
            if (c == 0) check("stageMask", 16'(mk[k]), 16'(stageMask));
            check("configBad", 16'(bad), 16'(configBad));
         end
      end
   endtask : t_decim
   task automatic stream(input int n, input int g, input logic cmp, input int expI,
         input int expQ, input logic tst, input logic [SAMPLE_W-1:0] pat);
      int ni;
      int nq;
      ni = 0;
      nq = 0;
      @(posedge core_clk);
      run <= 1'b1;
      for (int i = 1; i < n + 5; i++) begin
         @(posedge core_clk);
         if (i == n) run <= 1'b0;
         #1;
         if (firstValid === 1'b1) check("firstI", 16'(tst ? pat : lastI), 16'(firstI));
         if (secondIValid === 1'b1) ni++;
         if (secondQValid === 1'b1) nq++;
         if (cmp && secondIValid === 1'b1)
            check("secondI", 16'(tst ? pat : lastI << g), 16'(secondI));
         if (cmp && secondQValid === 1'b1)
            check("secondQ", 16'(tst ? pat : lastQ << g), 16'(secondQ));
      end
      check("secondI count", 16'(expI), 16'(ni));
      check("secondQ count", 16'(expQ), 16'(nq));
   endtask : stream
   task automatic t_stream();
      logic [SAMPLE_W-1:0] pats [3] = '{14'h0000, POS_FULL, NEG_FULL};
      wr(PHASE_STEP_BASE + 12'h005, 8'h01);
      rc(PHASE_STEP_BASE + 12'h005, 8'h01);
      wr(SECOND_PATH_EXTENDED_DECIMATION, 8'h70);
      wr(SECOND_PATH_CONFIGURATION, 8'h13);
      stream(8, 0, 1'b1, 4, 4, 1'b0, 14'h0000);
      wr(SECOND_PATH_CONFIGURATION, 8'h53);
      stream(8, 1, 1'b1, 4, 4, 1'b0, 14'h0000);
      wr(FIRST_PATH_TEST_ENABLE, 8'h01);
      // IF test mode puts the same pattern on the second path
      wr(SECOND_PATH_CONFIGURATION, 8'h73);
      for (int p = 0; p < 3; p++) begin
         wr(TEST_PATTERN_CONFIG, 8'(p + 1));
         stream(4, 1, 1'b1, 2, 2, 1'b1, pats[p]);
      end
      wr(FIRST_PATH_TEST_ENABLE, 8'h00);
      wr(SECOND_PATH_CONFIGURATION, 8'h18);
      stream(8, 0, 1'b0, 4, 0, 1'b0, 14'h0000);
      wr(SECOND_PATH_CONFIGURATION, 8'h1F);
      stream(8, 0, 1'b0, 0, 0, 1'b0, 14'h0000);
      rc(SECOND_PATH_STATUS, 8'h83);
      // 44 valid samples stepped the accumulator top byte by one each
      check("ncoPhase", 16'h00D1, 16'(ncoPhase[47:40]));
   endtask : t_stream
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs();
      t_decim();
      t_stream();
      report_and_stop();
   end
endmodule : ddc_decimation_config_tb
